// [hdl/frm_defines.svh]
// Offsets, field positions, reset values and timing counts of the
// flash read-mode interface. Included by the package and the design.
`ifndef FRM_DEFINES_SVH
`define FRM_DEFINES_SVH

// ============================================================
// Widths
`define FRM_AW 23
`define FRM_DW 16
`define FRM_CW 18

// ============================================================
// Register offsets (byte addresses)
`define FRM_OFS_CFG 8'h00
`define FRM_OFS_STAT 8'h04

// ============================================================
// Configuration field positions
`define FRM_ASYNC_SEL_BIT 15
`define FRM_LAT_HI 13
`define FRM_LAT_LO 11
`define FRM_HOLD_POL 10
`define FRM_HOLD_TWO 9
`define FRM_EDGE_SEL 6
`define FRM_HOLD_FN 4
`define FRM_WRAP_OFF 3
`define FRM_LEN_HI 2
`define FRM_LEN_LO 0
`define FRM_SPACE_HI 17
`define FRM_SPACE_LO 16

// Burst length codes
`define FRM_LEN_4 3'h1
`define FRM_LEN_8 3'h2
`define FRM_LEN_16 3'h3
`define FRM_LEN_CONT 3'h7

// Power-on: synchronous, latency 2, rising edge, continuous, wait active low
`define FRM_CFG_RST 18'h01007

// ============================================================
// Timing
`define FRM_CLK_MHZ 100
`define FRM_STBY_NS 150
`define FRM_STBY_CYC ((`FRM_STBY_NS * `FRM_CLK_MHZ + 999) / 1000)
`define FRM_PWR_EDGES 2'h3

`endif

// [hdl/frm_pkg.sv]
// Types of the flash read-mode interface.
// Assumes frm_defines.svh is on the include path.
`include "frm_defines.svh"

package frm_pkg;

  // Read spaces selected by the last command
  typedef enum logic [1:0] {
    SP_ARRAY,
    SP_STATUS,
    SP_CFI,
    SP_SIG
  } frm_space_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ACC,
    ST_AOUT,
    ST_LAT,
    ST_DATA,
    ST_XWAIT,
    ST_END
  } frm_st_t;

  // Flash control pins arriving from the host
  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic le_n;
    logic k;
    logic [`FRM_AW-1:0] addr;
  } frm_pin_in_t;

  // Driven pins toward the host
  typedef struct packed {
    logic [`FRM_DW-1:0] dq;
    logic dq_oe;
    logic wt;
    logic wt_oe;
  } frm_pin_out_t;

  typedef struct packed {
    frm_pin_in_t m;
    frm_pin_in_t s;
    logic ce_d;
    logic le_d;
    logic k_d;
    logic [`FRM_CW-1:0] cfg;
    logic [31:0] prdata;
    frm_st_t st;
    logic [`FRM_AW-1:0] addr;
    logic [`FRM_AW-1:0] last_addr;
    logic [3:0] start_lo;
    logic [7:0] cnt;
    logic [4:0] beat;
    logic hold_ph;
    logic crossed;
    logic wait_act;
    logic armed;
    logic [`FRM_AW-3:0] page_tag;
    logic page_ok;
    logic [7:0] idle_cnt;
    logic standby;
    logic [1:0] pwr_cnt;
    logic pwr_done;
    logic [`FRM_DW-1:0] dq;
  } frm_state_t;

endpackage : frm_pkg

// [hdl/frm_read_if.sv]
// Operation
// - Async reads only when async select set
// - Async data source follows last command
// - Four-word page buffer, short page access
// - Standby after 150 ns bus inactivity, async mode only
// - Wait held deasserted in async mode
// - Burst starts at first valid edge
// - Internal increment after first-data latency
// - Lengths 4, 8, 16 or continuous
// - Hold bit: words last one or two
// - Sequential, wrap inside boundary or continue
// - Wrap-off zero wraps, one does not
// - Aligned start: same order both ways
// - Wait in latency, stalls, burst end
// - Continuous burst stalls at 16-word crossing
// - Stall count equals start offset, once
// - Polarity bit sets wait active level
// - Suspend keeps sensing and latched data
// - Resume where the burst stopped
// - Wait floats while output enable high
// - Single read repeats the same word
// - Non-array spaces use single reads
// - Power-up latch on third rising edge
//
// Read side of a NOR flash: host pins on PIN_IN/PIN_OUT, array and
// non-array data on ARR_/ALT_ ports (valid one cycle after address),
// configuration over APB. All host pins are asynchronous to SYS_CLK.
// CFG at 0x00: [17:16] read space, [15] async select, [13:11]
// first-data latency (0 acts as 1), [10] wait polarity, [9] two-cycle
// hold, [6] valid edge, [4] pin function, [3] wrap off, [2:0] length.
// STAT at 0x04, read only: [15] standby, [14] wait, [13] crossed,
// [12:10] state, [9:5] beat, [4:0] counter low bits.
// Unmapped addresses answer with PSLVERR and read zero.
//
// The implementer's own choices: the placing of the registers and the APB slave port.
`timescale 1ns/10ps
`default_nettype none
`include "frm_defines.svh"

module frm_read_if #(
  parameter int RAND_NS = 80,
  parameter int PAGE_NS = 30
) (
  input wire logic SYS_CLK,
  input wire logic NRST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire frm_pkg::frm_pin_in_t PIN_IN,
  output frm_pkg::frm_pin_out_t PIN_OUT,
  output logic [`FRM_AW-1:0] ARR_ADDR,
  input wire logic [`FRM_DW-1:0] ARR_RDATA,
  output frm_pkg::frm_space_t ALT_SPACE,
  input wire logic [`FRM_DW-1:0] ALT_RDATA,
  output logic STANDBY
);
  import frm_pkg::*;

  // Access counts round up; at least two so the data port has settled
  localparam int RAND_RAW = (RAND_NS * `FRM_CLK_MHZ + 999) / 1000;
  localparam int PAGE_RAW = (PAGE_NS * `FRM_CLK_MHZ + 999) / 1000;
  localparam logic [7:0] RAND_CYC = 8'(RAND_RAW < 2 ? 2 : RAND_RAW);
  localparam logic [7:0] PAGE_CYC = 8'(PAGE_RAW < 2 ? 2 : PAGE_RAW);
  localparam logic [7:0] STBY_CYC = 8'(`FRM_STBY_CYC);

  frm_state_t r;
  frm_state_t n;

  logic async_mode;
  logic [2:0] len;
  logic cont;
  logic wrap_on;
  logic single;
  logic vedge;
  logic rise;
  logic ce_fall;
  logic le_fall;
  logic activity;
  logic [`FRM_AW-1:0] msk;
  logic [`FRM_AW-1:0] inc;
  logic [`FRM_AW-1:0] nxt;
  logic [4:0] len_words;
  logic [`FRM_DW-1:0] src;
  logic [7:0] lat;
  logic wr_acc;
  logic rd_setup;
  logic hit;
  logic wait_lvl;

  // ============================================================
  // Configuration decode
  always_comb begin
    async_mode = r.cfg[`FRM_ASYNC_SEL_BIT];
    len = r.cfg[`FRM_LEN_HI:`FRM_LEN_LO];
    cont = (len == `FRM_LEN_CONT);
    // Wrap only applies to fixed lengths
    wrap_on = !r.cfg[`FRM_WRAP_OFF] && !cont;
    single = (r.cfg[`FRM_SPACE_HI:`FRM_SPACE_LO] != 2'(SP_ARRAY));
    lat = {5'h0, r.cfg[`FRM_LAT_HI:`FRM_LAT_LO]};
    if (lat == 8'h0) begin
      lat = 8'h1;
    end
    case (len)
      `FRM_LEN_4: begin
        len_words = 5'h4;
        msk = `FRM_AW'(4'h3);
      end
      `FRM_LEN_8: begin
        len_words = 5'h8;
        msk = `FRM_AW'(4'h7);
      end
      `FRM_LEN_16: begin
        len_words = 5'h10;
        msk = `FRM_AW'(4'hf);
      end
      default: begin
        len_words = 5'h0;
        msk = '1;
      end
    endcase
    if (!wrap_on) begin
      msk = '1;
    end
    inc = r.addr + `FRM_AW'(1);
    // Aligned starts give the same sequence either way
    nxt = (r.addr & ~msk) | (inc & msk);
    src = single ? ALT_RDATA : ARR_RDATA;
  end

  // ============================================================
  // Pin events, taken only from the second synchroniser stage
  always_comb begin
    rise = r.s.k && !r.k_d;
    vedge = r.cfg[`FRM_EDGE_SEL] ? (!r.s.k && r.k_d) : rise;
    ce_fall = !r.s.ce_n && r.ce_d;
    le_fall = !r.s.le_n && r.le_d;
    activity = ce_fall || (r.s.ce_n != r.ce_d) ||
               (r.s.addr != r.last_addr);
    hit = r.page_ok && (r.s.addr[`FRM_AW-1:2] == r.page_tag);
    wr_acc = PSEL && PENABLE && PWRITE;
    rd_setup = PSEL && !PENABLE && !PWRITE;
  end

  // ============================================================
  // Next state
  always_comb begin
    n = r;
    n.m = PIN_IN;
    n.s = r.m;
    n.ce_d = r.s.ce_n;
    n.le_d = r.s.le_n;
    n.k_d = r.s.k;

    // APB register file
    if (wr_acc && PADDR == `FRM_OFS_CFG) begin
      n.cfg = PWDATA[`FRM_CW-1:0];
    end
    if (rd_setup) begin
      case (PADDR)
        `FRM_OFS_CFG: n.prdata = {14'h0, r.cfg};
        `FRM_OFS_STAT: n.prdata = {16'h0, r.standby, r.wait_act,
                                   r.crossed, r.st, r.beat, r.cnt[4:0]};
        default: n.prdata = 32'h0;
      endcase
    end

    // Bus inactivity timer; outputs stay driven in standby
    if (activity || !async_mode) begin
      n.idle_cnt = 8'h0;
      n.standby = 1'b0;
    end else if (r.idle_cnt < STBY_CYC) begin
      n.idle_cnt = r.idle_cnt + 8'h1;
    end else begin
      n.standby = 1'b1;
    end

    if (async_mode) begin
      // Clock ignored entirely here
      n.wait_act = 1'b0;
      n.armed = 1'b0;
      if (r.s.ce_n) begin
        n.st = ST_IDLE;
      end else if (ce_fall || r.s.addr != r.last_addr) begin
        n.last_addr = r.s.addr;
        n.addr = r.s.addr;
        n.cnt = hit ? PAGE_CYC : RAND_CYC;
        // Any upper-bit change loads a fresh page
        n.page_tag = r.s.addr[`FRM_AW-1:2];
        n.page_ok = 1'b1;
        n.st = ST_ACC;
      end else if (r.st == ST_ACC) begin
        n.cnt = r.cnt - 8'h1;
        if (r.cnt <= 8'h1) begin
          n.dq = src;
          n.st = ST_AOUT;
        end
      end
    end else begin
      n.page_ok = 1'b0;
      n.last_addr = r.s.addr;
      if (!r.s.ce_n && (ce_fall || le_fall) && !r.s.le_n) begin
        n.armed = 1'b1;
      end
      if (r.s.ce_n) begin
        n.st = ST_IDLE;
        n.armed = 1'b0;
        n.wait_act = 1'b0;
      end else if (vedge && r.armed) begin
        // Later of the two falls has passed: start a new burst
        n.armed = 1'b0;
        n.addr = r.s.addr;
        n.start_lo = r.s.addr[3:0];
        n.cnt = lat;
        n.beat = 5'h0;
        n.hold_ph = 1'b0;
        n.crossed = 1'b0;
        n.wait_act = 1'b1;
        n.pwr_done = 1'b1;
        n.st = ST_LAT;
      end else if (!r.pwr_done && rise && r.s.le_n && !r.s.oe_n) begin
        // Power-on burst with no latch pulse
        n.pwr_cnt = r.pwr_cnt + 2'h1;
        if (r.pwr_cnt + 2'h1 == `FRM_PWR_EDGES) begin
          n.pwr_done = 1'b1;
          n.addr = r.s.addr;
          n.start_lo = r.s.addr[3:0];
          n.cnt = lat;
          n.beat = 5'h0;
          n.hold_ph = 1'b0;
          n.crossed = 1'b0;
          n.wait_act = 1'b1;
          n.st = ST_LAT;
        end
      end else if (vedge) begin
        // No edges while suspended, so all state simply holds
        case (r.st)
          ST_LAT: begin
            n.cnt = r.cnt - 8'h1;
            if (r.cnt <= 8'h1) begin
              n.dq = src;
              n.wait_act = 1'b0;
              n.st = ST_DATA;
            end
          end
          ST_DATA: begin
            if (r.cfg[`FRM_HOLD_TWO] && !r.hold_ph) begin
              n.hold_ph = 1'b1;
            end else begin
              n.hold_ph = 1'b0;
              n.beat = r.beat + 5'h1;
              // Single reads count beats but keep their word
              if (!single) begin
                n.addr = nxt;
              end
              if (!cont && r.beat + 5'h1 == len_words) begin
                n.wait_act = 1'b1;
                n.st = ST_END;
              end else if (!single && !wrap_on && !r.crossed &&
                           nxt[3:0] == 4'h0 &&
                           r.start_lo[1:0] != 2'h0) begin
                n.crossed = 1'b1;
                n.cnt = {6'h0, r.start_lo[1:0]};
                n.wait_act = 1'b1;
                n.st = ST_XWAIT;
              end else begin
                if (!wrap_on && nxt[3:0] == 4'h0) begin
                  n.crossed = 1'b1;
                end
                // Array was fed nxt ahead of this edge, so it has settled
                n.dq = src;
              end
            end
          end
          ST_XWAIT: begin
            n.cnt = r.cnt - 8'h1;
            if (r.cnt <= 8'h1) begin
              n.dq = src;
              n.wait_act = 1'b0;
              n.st = ST_DATA;
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  // ============================================================
  // State register
  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      r <= '0;
      r.cfg <= `FRM_CFG_RST;
      // Pins read idle after reset so no false enable edge follows it
      r.m <= {3'h7, 1'b0, `FRM_AW'(0)};
      r.s <= {3'h7, 1'b0, `FRM_AW'(0)};
      r.ce_d <= 1'b1;
      r.le_d <= 1'b1;
    end else begin
      r <= n;
    end
  end

  // ============================================================
  // Outputs
  always_comb begin
    PREADY = 1'b1;
    PSLVERR = PSEL && PENABLE && (PADDR != `FRM_OFS_CFG) &&
              (PADDR != `FRM_OFS_STAT);
    PRDATA = r.prdata;
    // In data phase the array is fed the next address ahead of its edge
    ARR_ADDR = (r.st == ST_DATA) ? nxt : r.addr;
    ALT_SPACE = frm_space_t'(r.cfg[`FRM_SPACE_HI:`FRM_SPACE_LO]);
    STANDBY = r.standby;
    // Ready function drives the pin inactive; only wait is served here
    wait_lvl = r.wait_act && !r.cfg[`FRM_HOLD_FN] && !async_mode &&
               !r.s.oe_n;
    PIN_OUT.dq = r.dq;
    PIN_OUT.dq_oe = !r.s.ce_n && !r.s.oe_n;
    PIN_OUT.wt = r.cfg[`FRM_HOLD_POL] ? wait_lvl : !wait_lvl;
    // Gated by chip enable, released once output enable rises
    PIN_OUT.wt_oe = !r.s.ce_n && !r.s.oe_n;
  end

endmodule : frm_read_if
`default_nettype wire

// [hdl/_unused_placeholder_removed.sv]
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

// [test/frm_read_if_monitor.sv]
// Port assertions for frm_read_if, bound at the foot.
// Keeps its own shadow of the config word from APB writes.
`timescale 1ns/10ps
`default_nettype none
`include "frm_defines.svh"
module frm_read_mon (
  input wire logic SYS_CLK,
  input wire logic NRST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire frm_pkg::frm_pin_in_t PIN_IN,
  input wire frm_pkg::frm_pin_out_t PIN_OUT,
  input wire frm_pkg::frm_space_t ALT_SPACE,
  input wire logic STANDBY
);
  import frm_pkg::*;
  logic [`FRM_CW-1:0] cfg_r;
  logic acc;
  logic rd;
  assign acc = PSEL && PENABLE;
  assign rd = acc && !PWRITE;
  always_ff @(posedge SYS_CLK) begin
    if (!NRST)
      cfg_r <= `FRM_CFG_RST;
    else if (acc && PWRITE && PADDR == `FRM_OFS_CFG)
      cfg_r <= PWDATA[`FRM_CW-1:0];
  end
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!NRST);
  // =====================================================
  // Pins pass two sync stages, so three samples settle
  sequence oe_off_s;
    PIN_IN.oe_n [*3];
  endsequence
  sequence drv_on_s;
    (!PIN_IN.ce_n && !PIN_IN.oe_n) [*3];
  endsequence
  sequence async_s;
    (cfg_r[15] && !cfg_r[4] && $stable(cfg_r)) [*4];
  endsequence
  ready_high_a: assert property (acc |-> PREADY)
    else $error("pready low in access");
  map_err_a: assert property
    (acc |-> PSLVERR == (PADDR != 8'h00 && PADDR != 8'h04))
    else $error("pslverr wrong for address");
  err_zero_a: assert property (rd && PSLVERR |-> PRDATA == 32'h0)
    else $error("unmapped read not zero");
  cfg_read_a: assert property
    (rd && PADDR == `FRM_OFS_CFG |-> PRDATA == 32'(cfg_r))
    else $error("config readback wrong");
  stat_stby_a: assert property
    (rd && PADDR == `FRM_OFS_STAT |-> PRDATA[15] == $past(STANDBY))
    else $error("status standby bit wrong");
  space_follow_a: assert property
    ($stable(cfg_r) |-> ALT_SPACE == frm_space_t'(cfg_r[17:16]))
    else $error("space not from config");
  async_idle_a: assert property (async_s |-> PIN_OUT.wt == !cfg_r[10])
    else $error("wait active in async mode");
  wait_float_a: assert property (oe_off_s |-> !PIN_OUT.wt_oe)
    else $error("wait driven with oe high");
  keep_drive_a: assert property (drv_on_s |-> PIN_OUT.dq_oe)
    else $error("data not driven");
endmodule : frm_read_mon
bind frm_read_if frm_read_mon i_mon (.SYS_CLK, .NRST, .PSEL, .PENABLE,
  .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR, .PIN_IN,
  .PIN_OUT, .ALT_SPACE, .STANDBY);
`default_nettype wire

// [test/frm_array_model.sv]
// Storage behind the read interface: array and non-array words.
// Answers one clock after the address, as the interface expects.
`timescale 1ns/10ps
`default_nettype none
`include "frm_defines.svh"
module frm_array_model (
  input wire logic clk,
  input wire logic [`FRM_AW-1:0] addr,
  input wire frm_pkg::frm_space_t space,
  output logic [`FRM_DW-1:0] arr_data,
  output logic [`FRM_DW-1:0] alt_data
);
  import frm_pkg::*;
  always_ff @(posedge clk) begin
    arr_data <= addr[15:0] ^ 16'ha5a5;
    alt_data <= 16'h5a00 ^ {14'h0, space};
  end
endmodule : frm_array_model
`default_nettype wire

// [test/testbench.sv]
// Bench for frm_read_if: APB config plus host pin sequences.
// Needs frm_pkg, the array model and the monitor compiled first.
`timescale 1ns/10ps
`default_nettype none
`include "frm_defines.svh"
module testbench;
  import frm_pkg::*;
  logic clk, nrst, psel, penable, pwrite, pready, pslverr, stby, wl;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [15:0] ard, ald;
  logic [22:0] aad;
  frm_pin_in_t pin;
  frm_pin_out_t po;
  frm_space_t sp;
  int miscompares, num_checks;
  // Released wait line is pulled up
  assign wl = po.wt_oe ? po.wt : 1'b1;
  frm_read_if i_dut (.SYS_CLK(clk), .NRST(nrst), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .PIN_IN(pin),
    .PIN_OUT(po), .ARR_ADDR(aad), .ARR_RDATA(ard), .ALT_SPACE(sp),
    .ALT_RDATA(ald), .STANDBY(stby));
  frm_array_model i_arr (.clk(clk), .addr(aad), .space(sp),
    .arr_data(ard), .alt_data(ald));
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  task automatic check(input string s, input logic [31:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s exp %h seen %h", s, exp, seen);
    end
  endtask : check
  task automatic print_verdict;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : print_verdict
  task automatic apb(input logic wr, input logic [7:0] a,
    input logic [31:0] d);
    @(posedge clk);
    psel <= 1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    // Only the watchdog ends a wait that never sees pready
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    q = prdata;
    psel <= 0;
    penable <= 0;
  endtask : apb
  function automatic logic [15:0] aw(input logic [22:0] a);
    return a[15:0] ^ 16'ha5a5;
  endfunction : aw
  function automatic logic [31:0] cfgw(input logic [2:0] lat, ln,
    input logic pol, fe, wo, input logic [1:0] s);
    return {14'h0, s, 2'h0, lat, pol, 3'h0, fe, 2'h0, wo, ln};
  endfunction : cfgw
  // =====================================================
  // One burst; words sampled four cycles after each valid edge
  task automatic burst(input logic [31:0] cw, input logic [22:0] a,
    input int nw, input logic pu, sg, sus);
    logic [22:0] ix;
    int got, pre, mid, k, sz, ew;
    logic done, hp;
    hp = 0;
    got = 0;
    pre = 0;
    mid = 0;
    k = 0;
    done = 0;
    sz = 4 << (cw[1:0] - 2'h1);
    ew = ((cw[2:0] == 3'h7 || cw[3]) && a[3:0] + nw > 16) ? a[1:0] : 0;
    if (!pu)
      apb(1, `FRM_OFS_CFG, cw);
    pin.addr <= a;
    pin.ce_n <= 0;
    pin.oe_n <= 0;
    pin.le_n <= pu;
    cyc(4);
    while (got < nw && k < 100) begin
      k++;
      pin.k <= ~pin.k;
      cyc(4);
      if (k == 2)
        pin.le_n <= 1;
      if (pin.k == !cw[6] && k >= (pu ? 5 : 1)) begin
        if (wl === cw[10]) begin
          if (got == 0)
            pre++;
          else
            mid++;
        end else begin
          ix = (cw[3] || cw[2:0] == 3'h7) ? a + got
             : (a & ~(sz - 1)) | (a + got & sz - 1);
          check("word", po.dq, sg ? 16'h5a00 ^ cw[17:16] : aw(ix));
          // Two-cycle hold shows each word on two valid edges
          if (!cw[9] || hp)
            got++;
          hp = cw[9] && !hp;
        end
        if (sus && got == 2 && !done) begin
          done = 1;
          pin.oe_n <= 1;
          cyc(6);
          check("wait oe", po.wt_oe, 0);
          pin.oe_n <= 0;
          cyc(4);
        end
      end
    end
    if (cw[2:0] != 3'h7) begin
      pin.k <= ~pin.k;
      cyc(4);
      pin.k <= ~pin.k;
      cyc(4);
      check("end wait", wl, cw[10]);
    end
    check("latency", pre, cw[13:11]);
    check("stalls", mid, ew);
    pin.ce_n <= 1;
    pin.oe_n <= 1;
    pin.k <= 0;
    cyc(6);
    $display("burst at %h done", a);
  endtask : burst
  initial begin
    nrst = 0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    pin = '{1'b1, 1'b1, 1'b1, 1'b0, 23'h0};
    miscompares = 0;
    num_checks = 0;
    cyc(6);
    nrst <= 1;
    burst(32'h01007, 23'h40, 3, 1, 0, 0);
    apb(1, `FRM_OFS_STAT, 32'hffff);
    apb(0, 8'h08, 0);
    check("unmapped", q, 0);
    apb(0, `FRM_OFS_CFG, 0);
    check("cfg", q, 32'h01007);
    $display("register test done");
    apb(1, `FRM_OFS_CFG, 32'h08400);
    pin.ce_n <= 0;
    pin.oe_n <= 0;
    pin.addr <= 23'h100;
    cyc(14);
    check("random", po.dq, aw(23'h100));
    check("async wait", wl, 0);
    pin.addr <= 23'h102;
    cyc(8);
    check("page", po.dq, aw(23'h102));
    pin.addr <= 23'h106;
    cyc(7);
    check("new page", po.dq, aw(23'h102));
    cyc(9);
    check("new page", po.dq, aw(23'h106));
    repeat (4) begin
      pin.k <= ~pin.k;
      cyc(4);
    end
    check("clock", po.dq, aw(23'h106));
    cyc(30);
    check("standby", stby, 1);
    apb(0, `FRM_OFS_STAT, 0);
    check("stat standby", q[15], 1);
    apb(1, `FRM_OFS_CFG, 32'h38400);
    pin.addr <= 23'h200;
    cyc(14);
    check("signature", po.dq, 16'h5a03);
    pin.ce_n <= 1;
    pin.oe_n <= 1;
    cyc(6);
    $display("async test done");
    burst(cfgw(2, 1, 0, 0, 0, 0), 23'h2, 4, 0, 0, 1);
    burst(cfgw(3, 1, 0, 0, 1, 0), 23'hd, 4, 0, 0, 0);
    burst(cfgw(2, 2, 0, 0, 0, 0), 23'h10, 8, 0, 0, 0);
    burst(cfgw(2, 2, 0, 0, 1, 0), 23'h10, 8, 0, 0, 0);
    burst(cfgw(4, 3, 1, 1, 0, 0), 23'h7, 16, 0, 0, 0);
    burst(cfgw(1, 7, 0, 0, 0, 0), 23'he, 20, 0, 0, 0);
    burst(cfgw(2, 1, 0, 0, 1, 0) | 32'h200, 23'h14, 4, 0, 0, 0);
    burst(cfgw(2, 1, 0, 0, 0, 1), 23'h30, 4, 0, 1, 0);
    print_verdict;
  end
  initial begin
    cyc(20000);
    miscompares++;
    print_verdict;
  end
endmodule : testbench
`default_nettype wire
